// >>> rtl/ibd_pkg.sv
// Shared constants and state types for the instrument bus port pair
package ibd_pkg;

  // Control line positions inside the control vector
  localparam int unsigned L_DAV  = 0;
  localparam int unsigned L_NRFD = 1;
  localparam int unsigned L_NDAC = 2;
  localparam int unsigned L_EOI  = 3;
  localparam int unsigned L_ATN  = 4;
  localparam int unsigned L_IFC  = 5;
  localparam int unsigned L_REN  = 6;
  localparam int unsigned L_SRQ  = 7;

  // Released bus level after reset, all lines high
  localparam logic [7:0] BUS_IDLE = 8'hFF;

  // Address groups
  localparam logic [7:0] GRP_MASK   = 8'h60;
  localparam logic [7:0] GRP_LISTEN = 8'h20;
  localparam logic [7:0] GRP_TALK   = 8'h40;
  localparam logic [7:0] GRP_SECOND = 8'h60;

  // Multiline command codes
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] CMD_UNT = 8'h5F;

  // Request-service bit in the serial poll status byte
  localparam int unsigned STB_RQS = 6;

  // Attention settle time, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned ATN_SETTLE_NS  = 100;
  localparam int unsigned ATN_SETTLE_CYC = (ATN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  ATN_SETTLE_CNT = 5'(ATN_SETTLE_CYC);

  // Receive buffer shape: end flag plus byte, 32 deep
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_D = 32;

  // Acceptor handshake states
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_HOLD  = 2'b01,
    ACC_READY = 2'b10,
    ACC_TAKE  = 2'b11
  } ibd_acc_t;

  // Source handshake states
  typedef enum logic [1:0] {
    SRC_IDLE   = 2'b00,
    SRC_SETTLE = 2'b01,
    SRC_WAIT   = 2'b10,
    SRC_DAV    = 2'b11
  } ibd_src_t;

endpackage

// >>> rtl/ibd_bus_if.sv
// Open-collector bus joining the device end and the controller end
`timescale 1ns/1ps
interface ibd_bus_if;
  logic [7:0] dev_dio_o;   // Device data drive level
  logic [7:0] dev_dio_oe;  // Device data enables
  logic [7:0] dev_ctl_o;   // Device control drive level
  logic [7:0] dev_ctl_oe;  // Device control enables
  logic [7:0] ctr_dio_o;   // Controller data drive level
  logic [7:0] ctr_dio_oe;  // Controller data enables
  logic [7:0] ctr_ctl_o;   // Controller control drive level
  logic [7:0] ctr_ctl_oe;  // Controller control enables
  logic [7:0] dio_n;       // Resolved data wires, low is true
  logic [7:0] ctl_n;       // Resolved control wires, low is true

  // Any enabled driver pulling low wins; otherwise the pull-up holds high
  assign dio_n = ~((dev_dio_oe & ~dev_dio_o) | (ctr_dio_oe & ~ctr_dio_o));
  assign ctl_n = ~((dev_ctl_oe & ~dev_ctl_o) | (ctr_ctl_oe & ~ctr_ctl_o));

  modport dev (input dio_n, ctl_n, output dev_dio_o, dev_dio_oe, dev_ctl_o, dev_ctl_oe);
  modport ctr (input dio_n, ctl_n, output ctr_dio_o, ctr_dio_oe, ctr_ctl_o, ctr_ctl_oe);
endinterface

// >>> rtl/ibd_device_port.sv
// Device end of the instrument bus port, with its receive buffer
`timescale 1ns/1ps

module ibd_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 32
) (
  // Clock and reset
  input  logic         clk,
  input  logic         sys_rst,
  input  logic         clr,
  // Write side
  input  logic [W-1:0] in_data,
  input  logic         in_valid,
  output logic         in_ready,
  // Read side
  output logic [W-1:0] out_data,
  output logic         out_valid,
  input  logic         out_ready
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem [D];     // Storage words
  logic [AW-1:0] wr_reg;     // Write pointer
  logic [AW-1:0] rd_reg;     // Read pointer
  logic [AW:0]   cnt_reg;    // Occupancy

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];

  // Pointers and count; a clear empties the buffer at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (clr) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset so it maps to plain memory
  always_ff @(posedge clk) begin
    if (push) mem[wr_reg] <= in_data;
  end
endmodule

module ibd_device_port (
  // Clock and reset
  input  logic       clk,
  input  logic       sys_rst,
  // Bus
  ibd_bus_if.dev     bus,
  // Configuration
  input  logic [4:0] prim_addr,
  // Received device data
  output logic [7:0] rx_data,
  output logic       rx_eoi,
  output logic       rx_valid,
  input  logic       rx_ready,
  // Data to talk
  input  logic [7:0] tx_data,
  input  logic       tx_eoi,
  input  logic       tx_valid,
  output logic       tx_taken,
  // Service request
  input  logic       srq_req,
  input  logic [7:0] status_byte,
  // Interface state
  output logic       listen,
  output logic       talk,
  output logic       remote,
  output logic       lockout,
  output logic       spoll,
  output logic       dev_clr,
  output logic       trigger
);
  import ibd_pkg::*;

  // True when byte is the given address group aimed at us
  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] grp,
                                    input logic [4:0] a);
    addr_hit = ((b & GRP_MASK) == grp) && (b[4:0] == a);
  endfunction

  logic [7:0] dio_s1, dio_s2;   // Data synchroniser stages
  logic [7:0] ctl_s1, ctl_s2;   // Control synchroniser stages

  // Asynchronous bus into the clock domain
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dio_s1 <= BUS_IDLE;
      dio_s2 <= BUS_IDLE;
      ctl_s1 <= BUS_IDLE;
      ctl_s2 <= BUS_IDLE;
    end else begin
      dio_s1 <= bus.dio_n;
      dio_s2 <= dio_s1;
      ctl_s1 <= bus.ctl_n;
      ctl_s2 <= ctl_s1;
    end
  end

  // Low level on the wire reads as true
  wire [7:0] bus_byte = ~dio_s2;
  wire [7:0] ln       = ~ctl_s2;
  wire atn  = ln[L_ATN];
  wire ifc  = ln[L_IFC];
  wire ren  = ln[L_REN];
  wire dav  = ln[L_DAV];
  wire nrfd = ln[L_NRFD];
  wire ndac = ln[L_NDAC];

  ibd_acc_t   acc_reg, acc_next;  // Acceptor state
  ibd_src_t   src_reg, src_next;  // Source state
  logic [7:0] cmd_reg;            // Last byte taken, command or data
  logic       cmd_vld_reg;        // Command byte waiting to act
  logic       listen_reg, talk_reg, remote_reg, lockout_reg, spoll_reg;
  logic       ren_prev_reg;       // Remote enable one cycle ago
  logic       clr_reg, trig_reg, taken_reg;
  logic [7:0] out_reg;            // Byte being sourced
  logic       out_eoi_reg;
  logic [7:0] dio_oe_reg, ctl_oe_reg;
  logic       fifo_in_ready;

  // Every device takes part while attention is true
  wire acc_active = atn | listen_reg;
  wire acc_can    = atn | fifo_in_ready;       // Buffer space holds off the talker
  wire take       = (acc_reg == ACC_READY) & dav & acc_active;
  wire take_data  = take & ~atn;
  wire src_active = talk_reg & ~atn & ~ifc;
  wire src_load   = (src_reg == SRC_IDLE) & src_active & (spoll_reg | tx_valid);
  wire [7:0] stb  = {status_byte[7], srq_req, status_byte[5:0]};

  // Acceptor handshake
  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      ACC_IDLE:  if (acc_active) acc_next = ACC_HOLD;
      ACC_HOLD:  if (!acc_active || ifc) acc_next = ACC_IDLE;
                 else if (acc_can && !dav) acc_next = ACC_READY;
      ACC_READY: if (!acc_active || ifc) acc_next = ACC_IDLE;
                 else if (dav) acc_next = ACC_TAKE;
                 else if (!acc_can) acc_next = ACC_HOLD;
      ACC_TAKE:  if (!acc_active || ifc) acc_next = ACC_IDLE;
                 else if (!dav) acc_next = ACC_HOLD;
    endcase
  end

  // Source handshake; attention or clear aborts the byte
  always_comb begin
    src_next = src_reg;
    unique case (src_reg)
      SRC_IDLE:   if (src_load) src_next = SRC_WAIT;
      SRC_SETTLE: src_next = SRC_WAIT;
      SRC_WAIT:   if (!src_active) src_next = SRC_IDLE;
                  else if (!nrfd && ndac) src_next = SRC_DAV;
      SRC_DAV:    if (!src_active || !ndac) src_next = SRC_IDLE;
    endcase
  end

  // Decoded command, acted on the cycle after capture
  wire c_unl = cmd_vld_reg & (cmd_reg == CMD_UNL);
  wire c_unt = cmd_vld_reg & (cmd_reg == CMD_UNT);
  wire c_mla = cmd_vld_reg & ~c_unl & addr_hit(cmd_reg, GRP_LISTEN, prim_addr);
  wire c_mta = cmd_vld_reg & ~c_unt & addr_hit(cmd_reg, GRP_TALK, prim_addr);
  wire c_ota = cmd_vld_reg & ~c_unt & ~c_mta & ((cmd_reg & GRP_MASK) == GRP_TALK);
  wire c_sec = cmd_vld_reg & ((cmd_reg & GRP_MASK) == GRP_SECOND);
  wire c_cmd = cmd_vld_reg & ~c_sec;
  wire c_dcl = c_cmd & (cmd_reg == CMD_DCL);
  wire c_sdc = c_cmd & (cmd_reg == CMD_SDC) & listen_reg;
  wire c_gtl = c_cmd & (cmd_reg == CMD_GTL) & listen_reg;
  wire c_get = c_cmd & (cmd_reg == CMD_GET) & listen_reg;
  wire c_llo = c_cmd & (cmd_reg == CMD_LLO);
  wire c_spe = c_cmd & (cmd_reg == CMD_SPE);
  wire c_spd = c_cmd & (cmd_reg == CMD_SPD);
  wire c_clr = c_dcl | c_sdc;

  // Handshake states and command capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg     <= ACC_IDLE;
      src_reg     <= SRC_IDLE;
      cmd_reg     <= '0;
      cmd_vld_reg <= 1'b0;
    end else begin
      acc_reg     <= acc_next;
      src_reg     <= src_next;
      cmd_vld_reg <= take & atn;
      if (take) cmd_reg <= bus_byte;
    end
  end

  // Addressing state; clear has the final word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      listen_reg <= 1'b0;
      talk_reg   <= 1'b0;
    end else if (ifc) begin
      listen_reg <= 1'b0;
      talk_reg   <= 1'b0;
    end else begin
      if (c_unl || c_mta) listen_reg <= 1'b0;
      else if (c_mla) listen_reg <= 1'b1;
      if (c_unt || c_ota || c_mla) talk_reg <= 1'b0;
      else if (c_mta) talk_reg <= 1'b1;
    end
  end

  // Remote, lockout and serial poll modes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ren_prev_reg <= 1'b0;
      remote_reg   <= 1'b0;
      lockout_reg  <= 1'b0;
      spoll_reg    <= 1'b0;
    end else begin
      ren_prev_reg <= ren;
      if (!ren) remote_reg <= 1'b0;
      else if (!ren_prev_reg) remote_reg <= 1'b1;
      else if (c_gtl) remote_reg <= 1'b0;
      if (!ren) lockout_reg <= 1'b0;
      else if (c_llo) lockout_reg <= 1'b1;
      if (c_spe) spoll_reg <= 1'b1;
      else if (c_spd) spoll_reg <= 1'b0;
    end
  end

  // Byte to source: the status byte while polled, else user data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg     <= '0;
      out_eoi_reg <= 1'b0;
      taken_reg   <= 1'b0;
      clr_reg     <= 1'b0;
      trig_reg    <= 1'b0;
    end else begin
      taken_reg <= src_load & ~spoll_reg;
      clr_reg   <= c_clr;
      trig_reg  <= c_get;
      if (src_load) begin
        out_reg     <= spoll_reg ? stb : tx_data;
        out_eoi_reg <= spoll_reg ? 1'b0 : tx_eoi;
      end
    end
  end

  wire       src_on  = (src_next != SRC_IDLE);
  wire [7:0] src_byte = src_load ? (spoll_reg ? stb : tx_data) : out_reg;
  wire       src_eoi = src_load ? (~spoll_reg & tx_eoi) : out_eoi_reg;
  wire [7:0] ctl_oe_next;
  assign ctl_oe_next[L_DAV]  = (src_next == SRC_DAV);
  assign ctl_oe_next[L_NRFD] = (acc_next == ACC_HOLD) | (acc_next == ACC_TAKE);
  assign ctl_oe_next[L_NDAC] = (acc_next == ACC_HOLD) | (acc_next == ACC_READY);
  assign ctl_oe_next[L_EOI]  = src_on & src_eoi;
  assign ctl_oe_next[L_ATN]  = 1'b0;
  assign ctl_oe_next[L_IFC]  = 1'b0;
  assign ctl_oe_next[L_REN]  = 1'b0;
  assign ctl_oe_next[L_SRQ]  = srq_req;

  // Registered pin enables; a true bit pulls its wire low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dio_oe_reg <= '0;
      ctl_oe_reg <= '0;
    end else begin
      dio_oe_reg <= src_on ? src_byte : '0;
      ctl_oe_reg <= ctl_oe_next;
    end
  end

  ibd_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clr       (clr_reg),
    .in_data   ({ln[L_EOI], bus_byte}),
    .in_valid  (take_data),
    .in_ready  (fifo_in_ready),
    .out_data  ({rx_eoi, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  assign bus.dev_dio_o  = '0;
  assign bus.dev_dio_oe = dio_oe_reg;
  assign bus.dev_ctl_o  = '0;
  assign bus.dev_ctl_oe = ctl_oe_reg;
  assign tx_taken = taken_reg;
  assign listen   = listen_reg;
  assign talk     = talk_reg;
  assign remote   = remote_reg;
  assign lockout  = lockout_reg;
  assign spoll    = spoll_reg;
  assign dev_clr  = clr_reg;
  assign trigger  = trig_reg;
endmodule

// >>> rtl/ibd_ctrl_port.sv
// Controller end of the instrument bus: sources commands, accepts talker data
`timescale 1ns/1ps

module ibd_ctrl_port (
  // Clock and reset
  input  logic       clk,
  input  logic       sys_rst,
  // Bus
  ibd_bus_if.ctr     bus,
  // Bytes to send
  input  logic [7:0] cmd_data,
  input  logic       cmd_atn,
  input  logic       cmd_eoi,
  input  logic       cmd_valid,
  output logic       cmd_taken,
  // Uniline control
  input  logic       atn_release,
  input  logic       ren_req,
  input  logic       ifc_req,
  // Listening to the talker
  input  logic       listen_en,
  output logic [7:0] rx_data,
  output logic       rx_eoi,
  output logic       rx_strobe,
  output logic       srq_seen
);
  import ibd_pkg::*;

  logic [7:0] dio_s1, dio_s2, ctl_s1, ctl_s2;  // Synchroniser stages

  // Asynchronous bus into the clock domain
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dio_s1 <= BUS_IDLE;
      dio_s2 <= BUS_IDLE;
      ctl_s1 <= BUS_IDLE;
      ctl_s2 <= BUS_IDLE;
    end else begin
      dio_s1 <= bus.dio_n;
      dio_s2 <= dio_s1;
      ctl_s1 <= bus.ctl_n;
      ctl_s2 <= ctl_s1;
    end
  end

  wire [7:0] ln   = ~ctl_s2;
  wire       dav  = ln[L_DAV];
  wire       nrfd = ln[L_NRFD];
  wire       ndac = ln[L_NDAC];

  ibd_src_t   src_reg, src_next;  // Source state
  ibd_acc_t   acc_reg, acc_next;  // Acceptor state
  logic       atn_reg;            // Attention driven by us
  logic [4:0] cnt_reg;            // Attention settle count
  logic [7:0] out_reg;
  logic       eoi_reg, taken_reg, strobe_reg, srq_reg;
  logic [7:0] rx_reg;
  logic       rx_eoi_reg;
  logic [7:0] dio_oe_reg, ctl_oe_reg;

  wire load      = (src_reg == SRC_IDLE) & cmd_valid & ~ifc_req;
  wire atn_rise  = load & cmd_atn & ~atn_reg;
  wire acc_active = listen_en & ~atn_reg;
  wire take      = (acc_reg == ACC_READY) & dav;

  // Source handshake; a fresh attention waits out the settle time
  always_comb begin
    src_next = src_reg;
    unique case (src_reg)
      SRC_IDLE:   if (load) src_next = atn_rise ? SRC_SETTLE : SRC_WAIT;
      SRC_SETTLE: if (cnt_reg == '0) src_next = SRC_WAIT;
      SRC_WAIT:   if (ifc_req) src_next = SRC_IDLE;
                  else if (!nrfd && ndac) src_next = SRC_DAV;
      SRC_DAV:    if (ifc_req || !ndac) src_next = SRC_IDLE;
    endcase
  end

  // Acceptor handshake for talker data
  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      ACC_IDLE:  if (acc_active) acc_next = ACC_HOLD;
      ACC_HOLD:  if (!acc_active) acc_next = ACC_IDLE;
                 else if (!dav) acc_next = ACC_READY;
      ACC_READY: if (!acc_active) acc_next = ACC_IDLE;
                 else if (dav) acc_next = ACC_TAKE;
      ACC_TAKE:  if (!acc_active) acc_next = ACC_IDLE;
                 else if (!dav) acc_next = ACC_HOLD;
    endcase
  end

  // States, attention level and settle counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_reg <= SRC_IDLE;
      acc_reg <= ACC_IDLE;
      atn_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      src_reg <= src_next;
      acc_reg <= acc_next;
      if (load) atn_reg <= cmd_atn;
      else if (atn_release && src_reg == SRC_IDLE) atn_reg <= 1'b0;
      if (atn_rise) cnt_reg <= ATN_SETTLE_CNT - 5'd1;
      else if (cnt_reg != '0) cnt_reg <= cnt_reg - 5'd1;
    end
  end

  // Byte capture and strobes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg    <= '0;
      eoi_reg    <= 1'b0;
      taken_reg  <= 1'b0;
      strobe_reg <= 1'b0;
      rx_reg     <= '0;
      rx_eoi_reg <= 1'b0;
      srq_reg    <= 1'b0;
    end else begin
      taken_reg  <= load;
      strobe_reg <= take;
      srq_reg    <= ln[L_SRQ];
      if (load) begin
        out_reg <= cmd_data;
        eoi_reg <= cmd_eoi;
      end
      if (take) begin
        rx_reg     <= ~dio_s2;
        rx_eoi_reg <= ln[L_EOI];
      end
    end
  end

  wire src_on = (src_next != SRC_IDLE);
  wire [7:0] byte_now = load ? cmd_data : out_reg;
  wire [7:0] ctl_oe_next;
  assign ctl_oe_next[L_DAV]  = (src_next == SRC_DAV);
  assign ctl_oe_next[L_NRFD] = (acc_next == ACC_HOLD) | (acc_next == ACC_TAKE);
  assign ctl_oe_next[L_NDAC] = (acc_next == ACC_HOLD) | (acc_next == ACC_READY);
  assign ctl_oe_next[L_EOI]  = src_on & (load ? cmd_eoi : eoi_reg);
  assign ctl_oe_next[L_ATN]  = load ? cmd_atn : (atn_reg & ~(atn_release & src_reg == SRC_IDLE));
  assign ctl_oe_next[L_IFC]  = ifc_req;
  assign ctl_oe_next[L_REN]  = ren_req;
  assign ctl_oe_next[L_SRQ]  = 1'b0;

  // Registered pin enables; a true bit pulls its wire low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dio_oe_reg <= '0;
      ctl_oe_reg <= '0;
    end else begin
      dio_oe_reg <= src_on ? byte_now : '0;
      ctl_oe_reg <= ctl_oe_next;
    end
  end

  assign bus.ctr_dio_o  = '0;
  assign bus.ctr_dio_oe = dio_oe_reg;
  assign bus.ctr_ctl_o  = '0;
  assign bus.ctr_ctl_oe = ctl_oe_reg;
  assign cmd_taken = taken_reg;
  assign rx_data   = rx_reg;
  assign rx_eoi    = rx_eoi_reg;
  assign rx_strobe = strobe_reg;
  assign srq_seen  = srq_reg;
endmodule

// >>> verif/ibd_bus_checker.sv
// Concurrent checks on the shared instrument bus wires
`timescale 1ns/1ps
module ibd_bus_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Resolved wires, low is true
  input wire logic [7:0] dio_n,
  input wire logic [7:0] ctl_n,
  // Drive enables of both ends
  input wire logic [7:0] dev_dio_oe,
  input wire logic [7:0] ctr_dio_oe,
  input wire logic [7:0] dev_ctl_oe,
  input wire logic [7:0] ctr_ctl_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Every wire released on the first edge after reset
  chk_idle_release: assert property ($fell(sys_rst) |-> &{dio_n, ctl_n})
    else $error("bus not released after reset");
  // Data wire level follows enables only, drive level stays low
  chk_low_true: assert property (dio_n == ~(dev_dio_oe | ctr_dio_oe))
    else $error("data wire level not low-true");
  // Device never drives attention, clear or remote enable
  chk_ctl_owner: assert property (!(|dev_ctl_oe[6:4]))
    else $error("device drove a controller line");
  // Controller never asks for service
  chk_srq_owner: assert property (!ctr_ctl_oe[7])
    else $error("controller drove service request");
  // Only one source drives data valid
  chk_dav_owner: assert property (!(dev_ctl_oe[0] && ctr_ctl_oe[0]))
    else $error("two sources on data valid");
  // Data valid falls three cycles after ready and not-accepted were seen
  chk_dav_ready: assert property ($fell(ctl_n[0]) |-> $past(ctl_n[1], 3) && !$past(ctl_n[2], 3))
    else $error("data valid before acceptors ready");
  // No data valid soon after attention goes true
  chk_atn_settle: assert property ($fell(ctl_n[4]) |-> ctl_n[0] [*8])
    else $error("handshake started inside attention settle");
  // Acceptors pull not-ready low soon after data valid
  chk_accept_ans: assert property ($fell(ctl_n[0]) |-> ##[1:6] !ctl_n[1])
    else $error("no not-ready answer to data valid");
  // Source releases data valid soon after all acceptors took the byte
  chk_dav_drop: assert property ($rose(ctl_n[2]) && !ctl_n[0] |-> ##[1:6] ctl_n[0])
    else $error("data valid held after acceptance");
  // Byte and end marker stand while data valid is true
  chk_dio_hold: assert property (!ctl_n[0] && !$past(ctl_n[0]) |-> $stable({dio_n, ctl_n[3]}))
    else $error("data changed under data valid");
endmodule

// >>> verif/instrument_bus_device_port_tb.sv
// Testbench joining the device end and the controller end
`timescale 1ns/1ps
module instrument_bus_device_port_tb;
  import ibd_pkg::*;
  localparam logic [4:0] ADDR = 5'h16;  // Primary address of the device
  // Clock, reset and bookkeeping
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  int         n_mismatch = 0, num_checks = 0, n_clr = 0, n_trg = 0, cyc = 0;
  logic [8:0] got[$];                   // Bytes taken by the controller
  // Device user side
  logic [7:0] tx_data, rx_data, status_byte;
  logic       rx_ready, tx_eoi, tx_valid, tx_taken, srq_req, rx_eoi, rx_valid;
  logic       listen, talk, remote, lockout, spoll, dev_clr, trigger;
  // Controller user side
  logic [7:0] cmd_data, c_rx_data;
  logic       cmd_atn, cmd_eoi, cmd_valid, cmd_taken, atn_release;
  logic       ren_req, ifc_req, listen_en, c_rx_eoi, c_rx_strobe, srq_seen;

  ibd_bus_if bus ();
  ibd_device_port u_ibd_device_port (.clk, .sys_rst, .bus(bus.dev), .prim_addr(ADDR),
    .rx_data, .rx_eoi, .rx_valid, .rx_ready, .tx_data, .tx_eoi, .tx_valid, .tx_taken,
    .srq_req, .status_byte, .listen, .talk, .remote, .lockout, .spoll, .dev_clr, .trigger);
  ibd_ctrl_port u_ibd_ctrl_port (.clk, .sys_rst, .bus(bus.ctr), .cmd_data, .cmd_atn,
    .cmd_eoi, .cmd_valid, .cmd_taken, .atn_release, .ren_req, .ifc_req, .listen_en,
    .rx_data(c_rx_data), .rx_eoi(c_rx_eoi), .rx_strobe(c_rx_strobe), .srq_seen);
  ibd_bus_checker u_ibd_bus_checker (.clk, .sys_rst, .dio_n(bus.dio_n), .ctl_n(bus.ctl_n),
    .dev_dio_oe(bus.dev_dio_oe), .ctr_dio_oe(bus.ctr_dio_oe),
    .dev_ctl_oe(bus.dev_ctl_oe), .ctr_ctl_oe(bus.ctr_ctl_oe));

  always #2.5 clk = ~clk;

  // Pulse counters, controller capture and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dev_clr) n_clr <= n_clr + 1;
    if (trigger) n_trg <= n_trg + 1;
    if (c_rx_strobe) got.push_back({c_rx_eoi, c_rx_data});
    if (cyc == 20000) begin  // Far beyond a healthy run
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait n edges, then step off the edge before driving
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Hand one byte to the controller, held until it is taken
  task automatic put(input logic [7:0] b, input logic a, input logic e);
    cmd_data = b;
    cmd_atn = a;
    cmd_eoi = e;
    cmd_valid = 1'b1;
    do wt(1); while (cmd_taken !== 1'b1);
    cmd_valid = 1'b0;
  endtask

  // Full byte transfer: wait for data valid to come and go
  task automatic send(input logic [7:0] b, input logic a = 1'b1, input logic e = 1'b0);
    put(b, a, e);
    while (bus.ctl_n[0] !== 1'b0) wt(1);
    while (bus.ctl_n[0] !== 1'b1) wt(1);
    wt(3);
  endtask

  // Device talks one byte
  task automatic tx(input logic [7:0] b, input logic e);
    tx_data = b;
    tx_eoi = e;
    tx_valid = 1'b1;
    do wt(1); while (tx_taken !== 1'b1);
    tx_valid = 1'b0;
    wt(1);
  endtask

  // Drain one byte from the device buffer and compare it
  task automatic pop(input logic [8:0] exp);
    while (rx_valid !== 1'b1) wt(1);
    chk("rx byte", {rx_eoi, rx_data}, exp);
    rx_ready = 1'b1;
    wt(1);
    rx_ready = 1'b0;
    wt(1);
  endtask

  initial begin
    {rx_ready, tx_eoi, tx_valid, srq_req, cmd_atn, cmd_eoi, cmd_valid} = '0;
    {atn_release, ren_req, ifc_req, listen_en} = '0;
    {tx_data, cmd_data} = '0;
    status_byte = 8'h05;
    wt(20);
    sys_rst = 1'b0;
    wt(2);
    chk("idle state", {listen, talk, remote, lockout, spoll}, 9'h000);
    // Remote and lockout need no addressing
    ren_req = 1'b1;
    wt(8);
    chk("remote", remote, 1'b1);
    send(CMD_LLO);
    chk("lockout", lockout, 1'b1);
    // Listen addressing, then secondary and other talker ignored
    send(CMD_UNL);
    send(8'h20 | ADDR);
    chk("listen addr", {listen, talk}, 2'b10);
    send(8'h60 | ADDR);
    send(8'h40 | (ADDR ^ 5'h01));
    chk("secondary", {listen, talk}, 2'b10);
    // Addressed commands while listening
    send(CMD_SDC);
    send(CMD_GET);
    send(CMD_GTL);
    chk("addressed", {n_clr[1:0], n_trg[1:0], remote}, 9'h00A);
    // Fill the 32-word buffer, then one more must be refused
    atn_release = 1'b1;
    for (int i = 0; i < 32; i++) send(8'(i * 5 + 1), 1'b0, i == 31);
    put(8'hA5, 1'b0, 1'b1);
    wt(60);
    chk("full refuse", bus.ctl_n[0], 1'b1);
    for (int i = 0; i < 32; i++) pop({i == 31, 8'(i * 5 + 1)});
    pop(9'h1A5);
    // Unlisten, then addressed clear ignored and universal clear honoured
    atn_release = 1'b0;
    send(CMD_UNL);
    chk("unlisten", listen, 1'b0);
    send(CMD_SDC);
    send(CMD_DCL);
    chk("dev clear", n_clr[3:0], 4'h2);
    // Talk two bytes to the controller, end marker on the last
    send(8'h40 | ADDR);
    chk("talk addr", {listen, talk}, 2'b01);
    atn_release = 1'b1;
    listen_en = 1'b1;
    tx(8'h4E, 1'b0);
    tx(8'h8D, 1'b1);
    while (got.size() < 2) wt(1);
    chk("talk byte0", got[0], 9'h04E);
    chk("talk byte1", got[1], 9'h18D);
    listen_en = 1'b0;
    atn_release = 1'b0;
    // Let the talker drop data valid before attention returns
    wt(4);
    // Serial poll mode and service request
    srq_req = 1'b1;
    send(CMD_SPE);
    chk("poll on", {spoll, srq_seen}, 2'b11);
    // Polled talker sends the status byte with the service bit set
    atn_release = 1'b1;
    listen_en = 1'b1;
    while (got.size() < 3) wt(1);
    chk("poll byte", got[2], 9'h045);
    listen_en = 1'b0;
    wt(10);
    atn_release = 1'b0;
    send(CMD_SPD);
    chk("poll off", spoll, 1'b0);
    send(CMD_UNT);
    chk("untalk", talk, 1'b0);
    // Interface clear drops a fresh listener
    send(8'h20 | ADDR);
    chk("relisten", listen, 1'b1);
    ifc_req = 1'b1;
    wt(8);
    ifc_req = 1'b0;
    chk("ifc idle", {listen, talk}, 2'b00);
    wt(4);
    wrap_up();
  end
endmodule
